/* verilog/rtlp_cfg.svh */
`ifndef RTLP_CFG_SVH
`define RTLP_CFG_SVH
// Register byte offsets
`define RTLP_CTRL_OFS 8'h00
`define RTLP_RTC_CNT_OFS 8'h04
`define RTLP_ALARM0_OFS 8'h08
`define RTLP_ALARM1_OFS 8'h0c
`define RTLP_ALARM2_OFS 8'h10
`define RTLP_STATUS_OFS 8'h14
`define RTLP_MASK_OFS 8'h18
`define RTLP_RSTEN_OFS 8'h1c
`define RTLP_WAKEEN_OFS 8'h20
`define RTLP_LPT_CNT_OFS 8'h24
`define RTLP_LPT_THR_OFS 8'h28
`define RTLP_PWM_DUTY_OFS 8'h2c
// Control bit positions
`define RTLP_C_RTC_EN 0
`define RTLP_C_AL_CLR 1
`define RTLP_C_CLK_SEL 2
`define RTLP_C_CLK_OUT 3
`define RTLP_C_LPT_EN 4
`define RTLP_C_LPT_EXT 5
`define RTLP_C_LPT_FALL 6
`define RTLP_C_LPT_CLR 7
`define RTLP_C_PWM_EN 8
`define RTLP_C_MCD_EN 9
// Status bit positions
`define RTLP_S_AL0 0
`define RTLP_S_MCD 3
`define RTLP_S_OVF 4
`define RTLP_S_THR 5
`define RTLP_NEV 6
// Missing-clock window in fast cycles
`define RTLP_MCD_WIN 16'h4000
// Reset values and control field width
`define RTLP_CTRL_W 10
`define RTLP_ALARM_RST 32'hffff_ffff
`define RTLP_THR_RST 32'hffff_ffff
`define RTLP_ZERO32 32'h0000_0000
`endif

/* verilog/rtlp_pkg.sv */
`default_nettype none
package rtlp_pkg;
  typedef enum logic [1:0] {
    RTLP_IDLE = 2'b01,
    RTLP_DATA = 2'b10
  } rtlp_bus_t;
endpackage : rtlp_pkg
`default_nettype wire

/* verilog/rtlp_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module rtlp_edge (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic din,
  output logic rise,
  output logic fall,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;
  assign level = s2;
endmodule : rtlp_edge
`default_nettype wire

/* verilog/rtlp_top.sv */
// Overview of operation
// - 32-bit counter advances each slow clock tick
// - Three alarm comparators, each raises own event
// - Optional alarm zero match clears counter
// - Missing slow clock raises its own event
// - Events routed to interrupt, reset, wake
// - Slow clock selects internal or crystal source
// - Optional buffered slow clock output pin
// - Low-power timer has its own enable bit
// - Timer counts slow clock or external edges
// - Overflow and threshold match flags separately
// - Optional clear on threshold match, square wave
// - PWM output with programmable period, duty
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rtlp_cfg.svh"
module rtlp_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic lfosc_clk,
  input wire logic xtal_clk,
  input wire logic ext_count_in,
  output logic clk_out,
  output logic clk_out_oe,
  output logic square_out,
  output logic pwm_out,
  output logic irq,
  output logic reset_req,
  output logic wake_req
);
  function automatic logic match32(input logic [31:0] a, input logic [31:0] b);
    match32 = (a == b);
  endfunction : match32

  // Register decode shared by the read select
  function automatic logic at_ofs(input logic [7:0] a, input logic [7:0] ofs);
    at_ofs = (a == ofs);
  endfunction : at_ofs

  logic [31:0] ctrl;
  logic [31:0] rtc_cnt;
  logic [31:0] alarm [0:2];
  logic [`RTLP_NEV-1:0] status;
  logic [`RTLP_NEV-1:0] mask;
  logic [`RTLP_NEV-1:0] rsten;
  logic [`RTLP_NEV-1:0] wakeen;
  logic [31:0] lpt_cnt;
  logic [31:0] lpt_thr;
  logic [31:0] pwm_duty;
  logic [15:0] mcd_cnt;
  logic mcd_seen;
  logic sq_q;
  logic pwm_q;
  logic clk_out_q;

  // Bus pipeline
  rtlp_pkg::rtlp_bus_t bus_st;
  logic [7:0] a_q;
  logic w_q;
  wire take = hsel & hready & htrans[1];
  wire [7:0] ra = {haddr[7:2], 2'b00};
  wire wr = (bus_st == rtlp_pkg::RTLP_DATA) & w_q;
  wire wr_ctrl = wr & (a_q == `RTLP_CTRL_OFS);
  wire wr_rtc = wr & (a_q == `RTLP_RTC_CNT_OFS);
  wire wr_al0 = wr & (a_q == `RTLP_ALARM0_OFS);
  wire wr_al1 = wr & (a_q == `RTLP_ALARM1_OFS);
  wire wr_al2 = wr & (a_q == `RTLP_ALARM2_OFS);
  wire wr_stat = wr & (a_q == `RTLP_STATUS_OFS);
  wire wr_mask = wr & (a_q == `RTLP_MASK_OFS);
  wire wr_rsten = wr & (a_q == `RTLP_RSTEN_OFS);
  wire wr_wake = wr & (a_q == `RTLP_WAKEEN_OFS);
  wire wr_lpt = wr & (a_q == `RTLP_LPT_CNT_OFS);
  wire wr_thr = wr & (a_q == `RTLP_LPT_THR_OFS);
  wire wr_duty = wr & (a_q == `RTLP_PWM_DUTY_OFS);

  // Write strobes act in the data phase, one cycle after the address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st <= rtlp_pkg::RTLP_IDLE;
    end else begin
      bus_st <= take ? rtlp_pkg::RTLP_DATA : rtlp_pkg::RTLP_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_q <= 8'h00;
      w_q <= 1'b0;
    end else if (take) begin
      a_q <= ra;
      w_q <= hwrite;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Slow clock sources arrive asynchronously
  logic lf_rise;
  logic xt_rise;
  logic lf_lvl;
  logic xt_lvl;
  logic ext_rise;
  logic ext_fall;
  rtlp_edge u_lf (.hclk(hclk), .hresetn(hresetn), .din(lfosc_clk),
    .rise(lf_rise), .fall(),
    .level(lf_lvl));
  rtlp_edge u_xt (.hclk(hclk), .hresetn(hresetn), .din(xtal_clk),
    .rise(xt_rise), .fall(),
    .level(xt_lvl));
  rtlp_edge u_ext (.hclk(hclk), .hresetn(hresetn), .din(ext_count_in), .rise(ext_rise), .fall(ext_fall),
    .level());
  wire sel_xt = ctrl[`RTLP_C_CLK_SEL];
  wire tick = sel_xt ? xt_rise : lf_rise;
  wire tclk_lvl = sel_xt ? xt_lvl : lf_lvl;

  // Real-time counter and alarms
  wire rtc_en = ctrl[`RTLP_C_RTC_EN];
  wire [2:0] al_hit;
  assign al_hit[0] = rtc_en & tick & match32(rtc_cnt, alarm[0]);
  assign al_hit[1] = rtc_en & tick & match32(rtc_cnt, alarm[1]);
  assign al_hit[2] = rtc_en & tick & match32(rtc_cnt, alarm[2]);
  wire rtc_clr = al_hit[0] & ctrl[`RTLP_C_AL_CLR];
  wire [31:0] next_rtc = rtc_clr ? `RTLP_ZERO32 : rtc_cnt + 32'h0000_0001;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rtc_cnt <= 32'h0000_0000;
    end else if (wr_rtc) begin
      rtc_cnt <= hwdata;
    end else if (rtc_en & tick) begin
      rtc_cnt <= next_rtc;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm[0] <= `RTLP_ALARM_RST;
    end else if (wr_al0) begin
      alarm[0] <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm[1] <= `RTLP_ALARM_RST;
    end else if (wr_al1) begin
      alarm[1] <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm[2] <= `RTLP_ALARM_RST;
    end else if (wr_al2) begin
      alarm[2] <= hwdata;
    end
  end

  // Missing clock: no slow edge within the window
  wire mcd_en = ctrl[`RTLP_C_MCD_EN];
  wire mcd_full = (mcd_cnt == `RTLP_MCD_WIN);
  wire mcd_hit = mcd_en & ~tick & mcd_full & ~mcd_seen;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mcd_cnt <= 16'h0000;
    end else if (!mcd_en || tick) begin
      mcd_cnt <= 16'h0000;
    end else if (!mcd_full) begin
      mcd_cnt <= mcd_cnt + 16'h0001;
    end
  end

  // One event per outage: held off until the next slow edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mcd_seen <= 1'b0;
    end else if (!mcd_en || tick) begin
      mcd_seen <= 1'b0;
    end else if (mcd_full) begin
      mcd_seen <= 1'b1;
    end
  end

  // Low-power timer
  wire lpt_en = ctrl[`RTLP_C_LPT_EN];
  wire ext_edge = ctrl[`RTLP_C_LPT_FALL] ? ext_fall : ext_rise;
  wire lpt_inc = lpt_en & (ctrl[`RTLP_C_LPT_EXT] ? ext_edge : tick);
  wire lpt_ovf = lpt_inc & (lpt_cnt == 32'hffff_ffff);
  wire lpt_match = lpt_inc & match32(lpt_cnt, lpt_thr);
  wire lpt_clr = lpt_match & ctrl[`RTLP_C_LPT_CLR];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lpt_cnt <= 32'h0000_0000;
    end else if (wr_lpt) begin
      lpt_cnt <= hwdata;
    end else if (lpt_clr) begin
      lpt_cnt <= 32'h0000_0000;
    end else if (lpt_inc) begin
      lpt_cnt <= lpt_cnt + 32'h0000_0001;
    end
  end

  // Square wave: one half period per threshold match
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sq_q <= 1'b0;
    end else if (lpt_match) begin
      sq_q <= ~sq_q;
    end
  end

  // PWM: period from threshold, high while count below duty
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= ctrl[`RTLP_C_PWM_EN] & (lpt_cnt < pwm_duty);
    end
  end

  // Clock copy lags the pin by three fast cycles: two synchroniser stages and this register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_out_q <= 1'b0;
    end else begin
      clk_out_q <= ctrl[`RTLP_C_CLK_OUT] & tclk_lvl;
    end
  end
  assign square_out = sq_q;
  assign pwm_out = pwm_q;
  assign clk_out = clk_out_q;
  assign clk_out_oe = ctrl[`RTLP_C_CLK_OUT];

  // Sticky events; set wins over the write-one clear
  wire [`RTLP_NEV-1:0] ev = {lpt_match, lpt_ovf, mcd_hit, al_hit};
  wire [`RTLP_NEV-1:0] clr = wr_stat ? hwdata[`RTLP_NEV-1:0] : {`RTLP_NEV{1'b0}};
  wire [`RTLP_NEV-1:0] next_status = (status & ~clr) | ev;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= {`RTLP_NEV{1'b0}};
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `RTLP_ZERO32;
    end else if (wr_ctrl) begin
      ctrl <= {{(32 - `RTLP_CTRL_W){1'b0}}, hwdata[`RTLP_CTRL_W-1:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask <= {`RTLP_NEV{1'b0}};
    end else if (wr_mask) begin
      mask <= hwdata[`RTLP_NEV-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsten <= {`RTLP_NEV{1'b0}};
    end else if (wr_rsten) begin
      rsten <= hwdata[`RTLP_NEV-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wakeen <= {`RTLP_NEV{1'b0}};
    end else if (wr_wake) begin
      wakeen <= hwdata[`RTLP_NEV-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lpt_thr <= `RTLP_THR_RST;
    end else if (wr_thr) begin
      lpt_thr <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_duty <= `RTLP_ZERO32;
    end else if (wr_duty) begin
      pwm_duty <= hwdata;
    end
  end

  wire [`RTLP_NEV-1:0] irq_src = status & mask;
  wire [`RTLP_NEV-1:0] rst_src = status & rsten;
  wire [`RTLP_NEV-1:0] wake_src = status & wakeen;
  assign irq = |irq_src;
  assign reset_req = |rst_src;
  assign wake_req = |wake_src;

  // Read data, registered in the data phase
  // A read right behind a write to the same register returns the old value
  wire rd_ctrl = at_ofs(ra, `RTLP_CTRL_OFS);
  wire rd_rtc = at_ofs(ra, `RTLP_RTC_CNT_OFS);
  wire rd_al0 = at_ofs(ra, `RTLP_ALARM0_OFS);
  wire rd_al1 = at_ofs(ra, `RTLP_ALARM1_OFS);
  wire rd_al2 = at_ofs(ra, `RTLP_ALARM2_OFS);
  wire rd_stat = at_ofs(ra, `RTLP_STATUS_OFS);
  wire rd_mask = at_ofs(ra, `RTLP_MASK_OFS);
  wire rd_rsten = at_ofs(ra, `RTLP_RSTEN_OFS);
  wire rd_wake = at_ofs(ra, `RTLP_WAKEEN_OFS);
  wire rd_lpt = at_ofs(ra, `RTLP_LPT_CNT_OFS);
  wire rd_thr = at_ofs(ra, `RTLP_LPT_THR_OFS);
  wire rd_duty = at_ofs(ra, `RTLP_PWM_DUTY_OFS);
  wire [31:0] rd_mux =
    rd_ctrl ? ctrl :
    rd_rtc ? rtc_cnt :
    rd_al0 ? alarm[0] :
    rd_al1 ? alarm[1] :
    rd_al2 ? alarm[2] :
    rd_stat ? {{(32 - `RTLP_NEV){1'b0}}, status} :
    rd_mask ? {{(32 - `RTLP_NEV){1'b0}}, mask} :
    rd_rsten ? {{(32 - `RTLP_NEV){1'b0}}, rsten} :
    rd_wake ? {{(32 - `RTLP_NEV){1'b0}}, wakeen} :
    rd_lpt ? lpt_cnt :
    rd_thr ? lpt_thr :
    rd_duty ? pwm_duty : `RTLP_ZERO32;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      hrdata <= rd_mux;
    end
  end
endmodule : rtlp_top
`default_nettype wire

/* tb/rtlp_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtlp_cfg.svh"
module rtlp_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic clk_out,
  input wire logic clk_out_oe,
  input wire logic irq,
  input wire logic reset_req,
  input wire logic wake_req
);
  logic wr_ph;
  logic rd_ph;
  logic [7:0] a_q;
  logic [31:0] mask_q;
  wire take = hsel & hready & htrans[1];
  wire ctrl_wr = wr_ph && a_q == `RTLP_CTRL_OFS;
  // Track data phases and the mask value as software wrote it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      rd_ph <= 1'b0;
      a_q <= 8'h00;
      mask_q <= 32'h0000_0000;
    end else begin
      wr_ph <= take & hwrite;
      rd_ph <= take & ~hwrite;
      if (take) a_q <= haddr[7:0];
      if (wr_ph && a_q == `RTLP_MASK_OFS) mask_q <= hwdata;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_oe_off; (!clk_out_oe) [*3]; endsequence
  sequence s_wrote; $past(wr_ph) || $past(wr_ph, 2); endsequence
  property p_okay; hreadyout && !hresp; endproperty
  property p_oe_src; $changed(clk_out_oe) |-> $past(ctrl_wr); endproperty
  property p_clk_gate; s_oe_off |-> !clk_out; endproperty
  property p_rd_hold; $changed(hrdata) |-> rd_ph; endproperty
  property p_irq_fall; $fell(irq) |-> s_wrote; endproperty
  property p_rst_fall; $fell(reset_req) |-> s_wrote; endproperty
  property p_wake_fall; $fell(wake_req) |-> s_wrote; endproperty
  property p_irq_mask; irq |-> mask_q != 0 || $past(mask_q) != 0; endproperty
  a_okay: assert property (p_okay)
    else $error("bus answer not ready or not okay");
  a_oe_src: assert property (p_oe_src)
    else $error("clock output enable moved without control write");
  a_clk_gate: assert property (p_clk_gate)
    else $error("clock output active while disabled");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved outside a read");
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without a write");
  a_rst_fall: assert property (p_rst_fall)
    else $error("reset request dropped without a write");
  a_wake_fall: assert property (p_wake_fall)
    else $error("wake request dropped without a write");
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt with empty mask");
endmodule : rtlp_assertions
`default_nettype wire

/* tb/rtlp_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rtlp_top_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic lfosc_clk = 1'b0;
  logic xtal_clk = 1'b0;
  logic xt_run = 1'b1;
  logic ext_count_in = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, clk_out, clk_out_oe, square_out, pwm_out, irq, reset_req, wake_req;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  rtlp_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .lfosc_clk, .xtal_clk, .ext_count_in, .clk_out, .clk_out_oe,
    .square_out, .pwm_out, .irq, .reset_req, .wake_req);
  initial forever #2.5 hclk = ~hclk;
  initial forever #50 lfosc_clk = ~lfosc_clk;
  initial forever #150 xtal_clk = xt_run ? ~xtal_clk : xtal_clk;
  task automatic conclude;
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic chk_in(input string n, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
    chk(n, 32'h1, {31'h0, (g >= lo && g <= hi)});
  endtask : chk_in
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask : rd
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    rd(a, r);
    chk(n, e, r);
  endtask : rc
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt
  task automatic pulse(input int n);
    repeat (n) begin
      ext_count_in <= 1'b1;
      wt(6);
      ext_count_in <= 1'b0;
      wt(6);
    end
  endtask : pulse
  task automatic t_regs;
    rc("alarm0", 8'h08, 32'hffff_ffff);
    rc("threshold", 8'h28, 32'hffff_ffff);
    rc("ctrl", 8'h00, 32'h0);
    rc("unmapped", 8'h40, 32'h0);
  endtask : t_regs
  task automatic t_rtc;
    logic [31:0] v;
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h0);
    wt(200);
    rd(8'h04, v);
    chk_in("rtc_lfosc", 32'h5, 32'hc, v);
    wr(8'h00, 32'h5);
    wr(8'h04, 32'h0);
    wt(240);
    rd(8'h04, v);
    chk_in("rtc_xtal", 32'h3, 32'h5, v);
  endtask : t_rtc
  task automatic t_alarm;
    logic [31:0] v;
    wr(8'h00, 32'h1);
    wr(8'h0c, 32'h14);
    wr(8'h18, 32'h2);
    wr(8'h04, 32'h0);
    wt(500);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h18, 32'h0);
    wt(3);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rc("status", 8'h14, 32'h2);
    wr(8'h1c, 32'h2);
    wt(3);
    chk("reset_req", 32'h1, {31'h0, reset_req});
    wr(8'h1c, 32'h0);
    wr(8'h20, 32'h2);
    wt(3);
    chk("wake_req", 32'h1, {31'h0, wake_req});
    wr(8'h14, 32'h2);
    wt(3);
    chk("wake_cleared", 32'h0, {31'h0, wake_req});
    wr(8'h08, 32'h4);
    wr(8'h00, 32'h3);
    wr(8'h04, 32'h0);
    wt(400);
    rd(8'h04, v);
    chk_in("rtc_wrap", 32'h0, 32'h4, v);
    wr(8'h00, 32'h0);
    wr(8'h14, 32'hffff_ffff);
  endtask : t_alarm
  task automatic t_timer;
    wr(8'h00, 32'h30);
    wr(8'h24, 32'h0);
    pulse(5);
    rc("lpt_rise", 8'h24, 32'h5);
    wr(8'h00, 32'h70);
    wr(8'h24, 32'h0);
    pulse(3);
    rc("lpt_fall", 8'h24, 32'h3);
    wr(8'h00, 32'hb0);
    wr(8'h28, 32'h2);
    wr(8'h24, 32'h0);
    pulse(7);
    rc("lpt_wrap", 8'h24, 32'h1);
    rc("thr_flag", 8'h14, 32'h20);
    pulse(2);
    chk("square", 32'h1, {31'h0, square_out});
    wr(8'h14, 32'h30);
    wr(8'h24, 32'hffff_ffff);
    pulse(1);
    rc("ovf_flag", 8'h14, 32'h10);
  endtask : t_timer
  task automatic t_pwm_out;
    int hi;
    int seen;
    hi = 0;
    seen = 0;
    wr(8'h28, 32'h3);
    wr(8'h2c, 32'h2);
    wr(8'h00, 32'h198);
    wt(2);
    chk("clk_out_oe", 32'h1, {31'h0, clk_out_oe});
    repeat (400) begin
      @(posedge hclk);
      hi += int'(pwm_out === 1'b1);
      seen += int'(clk_out === 1'b1);
    end
    chk_in("pwm_high", 32'd150, 32'd250, hi);
    chk_in("clk_out_high", 32'd150, 32'd250, seen);
  endtask : t_pwm_out
  task automatic t_mcd;
    xt_run = 1'b0;
    wr(8'h00, 32'h204);
    wr(8'h14, 32'h3f);
    wt(16000);
    rc("mcd_early", 8'h14, 32'h0);
    wt(500);
    rc("mcd_flag", 8'h14, 32'h8);
    wr(8'h14, 32'h8);
    wt(100);
    rc("mcd_once", 8'h14, 32'h0);
  endtask : t_mcd
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    wt(3);
    hresetn <= 1'b1;
    wt(1);
    t_regs;
    t_rtc;
    t_alarm;
    t_timer;
    t_pwm_out;
    t_mcd;
    conclude;
  end
endmodule : rtlp_top_bench
bind rtlp_top rtlp_assertions chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .hrdata, .hreadyout, .hresp, .clk_out, .clk_out_oe, .irq, .reset_req, .wake_req);
`default_nettype wire
